// ---- dcc_defines.svh ----
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// address width of the system bus, in bits
`define DCC_ADDR_W 12
// number of general peripheral channels
`define DCC_NUM_CH 2
// code of the converter channel in the channel select
`define DCC_SEL_ADC 2'h2
// bytes stored per converter result (high byte, then low byte)
`define DCC_ADC_BYTES 2'h2
// converter result width
`define DCC_ADC_W 10
// bytes moved by a byte transfer and by a word transfer
`define DCC_STEP_BYTE 2'h1
`define DCC_STEP_WORD 2'h2
// trigger sources and the width of a trigger select
`define DCC_TRIG_N 8
`define DCC_TRIG_SEL_W 3
// depth of the buffer in the data path
`define DCC_BUF_DEPTH 2
// reset value of the current address
`define DCC_ADDR_RST 12'h000

`endif

// ---- dcc_pkg.sv ----
`include "dcc_defines.svh"

package dcc_pkg;

  typedef enum logic [2:0] {
    DCC_IDLE = 3'b000,
    DCC_REQ = 3'b001,
    DCC_RD = 3'b010,
    DCC_WR = 3'b011,
    DCC_FIN = 3'b100
  } dcc_state_e;

  typedef logic [`DCC_ADDR_W-1:0] dcc_addr_t;

  typedef struct packed {
    dcc_state_e state;
    logic [1:0] sel;
    logic [2:0] pend;
    logic [`DCC_NUM_CH-1:0] en;
    dcc_addr_t [`DCC_NUM_CH-1:0] cur;
    logic [1:0] rd_cnt;
    logic [1:0] wr_cnt;
    logic bus_req;
    logic bus_rd;
    logic bus_wr;
    dcc_addr_t bus_addr;
    logic [7:0] bus_wdata;
    logic [`DCC_NUM_CH-1:0] irq;
    logic adc_irq;
    logic adc_start;
    logic adc_busy;
    logic [`DCC_ADC_W-1:0] adc_res;
  } dcc_regs_s;

endpackage : dcc_pkg

// ---- dcc_buf_if.sv ----
`timescale 1ns/1ps

interface dcc_buf_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport store (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface : dcc_buf_if

// ---- dcc_buf.sv ----
`timescale 1ns/1ps

`include "dcc_defines.svh"

module dcc_buf #(
  parameter int DEPTH = `DCC_BUF_DEPTH,
  parameter int W = 8
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  dcc_buf_if.store buf_if
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } dcc_fifo_s;

  dcc_fifo_s r_q;
  dcc_fifo_s r_d;
  logic push;
  logic pop;

  assign buf_if.in_ready = (r_q.cnt != CW'(DEPTH));
  assign buf_if.out_valid = (r_q.cnt != '0);
  assign buf_if.out_data = r_q.mem[r_q.rp];
  assign push = buf_if.in_valid & buf_if.in_ready;
  assign pop = buf_if.out_valid & buf_if.out_ready;

  always_comb begin
    r_d = r_q;
    if (push) begin
      r_d.mem[r_q.wp] = buf_if.in_data;
      r_d.wp = (r_q.wp == PW'(DEPTH - 1)) ? '0 : r_q.wp + PW'(1);
    end
    if (pop) begin
      r_d.rp = (r_q.rp == PW'(DEPTH - 1)) ? '0 : r_q.rp + PW'(1);
    end
    if (push && !pop) begin
      r_d.cnt = r_q.cnt + CW'(1);
    end else if (pop && !push) begin
      r_d.cnt = r_q.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule : dcc_buf

// ---- dcc_top.sv ----
`timescale 1ns/1ps

`include "dcc_defines.svh"

module dcc_top #(
  parameter int TRIG_N = `DCC_TRIG_N
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [TRIG_N-1:0] trig_in,
  input wire logic [`DCC_NUM_CH-1:0][`DCC_TRIG_SEL_W-1:0] chan_trig_sel_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_enable_set_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_enable_clr_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_to_periph_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_word_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_irq_en_in,
  input wire logic [`DCC_NUM_CH-1:0] chan_single_pass_in,
  input wire dcc_pkg::dcc_addr_t [`DCC_NUM_CH-1:0] chan_start_addr_in,
  input wire dcc_pkg::dcc_addr_t [`DCC_NUM_CH-1:0] chan_end_addr_in,
  input wire dcc_pkg::dcc_addr_t [`DCC_NUM_CH-1:0] chan_periph_addr_in,
  input wire logic adc_enable_in,
  input wire logic adc_done_in,
  input wire logic [`DCC_ADC_W-1:0] adc_data_in,
  input wire dcc_pkg::dcc_addr_t adc_result_addr_in,
  input wire logic bus_ack_in,
  input wire logic [7:0] bus_rdata_in,
  output logic bus_req_out,
  output logic bus_rd_out,
  output logic bus_wr_out,
  output dcc_pkg::dcc_addr_t bus_addr_out,
  output logic [7:0] bus_wdata_out,
  output logic [`DCC_NUM_CH-1:0] chan_enable_out,
  output dcc_pkg::dcc_addr_t [`DCC_NUM_CH-1:0] chan_cur_addr_out,
  output logic [`DCC_NUM_CH-1:0] chan_irq_out,
  output logic adc_start_out,
  output logic adc_irq_out
);

  function automatic logic [1:0] dcc_nbytes(input logic word);
    return word ? `DCC_STEP_WORD : `DCC_STEP_BYTE;
  endfunction : dcc_nbytes

  dcc_pkg::dcc_regs_s r_q;
  dcc_pkg::dcc_regs_s r_d;

  dcc_buf_if #(.W(8)) data_if ();

  // the word waits here between its read and write halves; the write
  // side only drains in the write phase, so a word really fills it
  dcc_buf #(
    .DEPTH(`DCC_BUF_DEPTH),
    .W(8)
  ) u_buf (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .buf_if(data_if.store)
  );

  logic ch;
  logic is_adc;
  logic [1:0] nb;
  logic adc_push;
  dcc_pkg::dcc_addr_t rd_addr;
  dcc_pkg::dcc_addr_t wr_addr;
  dcc_pkg::dcc_addr_t chan_addr_rd;
  dcc_pkg::dcc_addr_t chan_addr_wr;
  dcc_pkg::dcc_addr_t per_addr_rd;
  dcc_pkg::dcc_addr_t per_addr_wr;

  assign ch = r_q.sel[0];
  assign is_adc = (r_q.sel == `DCC_SEL_ADC);
  assign nb = is_adc ? `DCC_ADC_BYTES : dcc_nbytes(chan_word_in[ch]);
  assign chan_addr_rd = r_q.cur[ch] + `DCC_ADDR_W'(r_q.rd_cnt);
  assign chan_addr_wr = r_q.cur[ch] + `DCC_ADDR_W'(r_q.wr_cnt);
  assign per_addr_rd = chan_periph_addr_in[ch] + `DCC_ADDR_W'(r_q.rd_cnt);
  assign per_addr_wr = chan_periph_addr_in[ch] + `DCC_ADDR_W'(r_q.wr_cnt);

  assign rd_addr = chan_to_periph_in[ch] ? chan_addr_rd : per_addr_rd;
  assign wr_addr = is_adc ? adc_result_addr_in + `DCC_ADDR_W'(r_q.wr_cnt)
                 : (chan_to_periph_in[ch] ? per_addr_wr : chan_addr_wr);

  // result bytes go straight into the buffer
  assign adc_push = (r_q.state == dcc_pkg::DCC_RD) && is_adc &&
                    (r_q.rd_cnt != `DCC_ADC_BYTES) && data_if.in_ready;

  always_comb begin
    data_if.in_valid = r_q.bus_rd | adc_push;
    data_if.in_data = bus_rdata_in;
    if (adc_push) begin
      data_if.in_data = (r_q.rd_cnt == 2'h0)
                      ? 8'(r_q.adc_res >> 8) : r_q.adc_res[7:0];
    end
    data_if.out_ready = (r_q.state == dcc_pkg::DCC_WR);
  end

  always_comb begin
    r_d = r_q;
    r_d.bus_rd = 1'b0;
    r_d.bus_wr = 1'b0;
    r_d.irq = '0;
    r_d.adc_irq = 1'b0;
    r_d.adc_start = 1'b0;

    unique case (r_q.state)
      dcc_pkg::DCC_IDLE: begin
        // fixed priority: channel zero, channel one, converter
        if (r_q.pend[0]) begin
          r_d.sel = 2'h0;
        end else if (r_q.pend[1]) begin
          r_d.sel = 2'h1;
        end else begin
          r_d.sel = `DCC_SEL_ADC;
        end
        if (r_q.pend != 3'h0) begin
          r_d.state = dcc_pkg::DCC_REQ;
          r_d.bus_req = 1'b1;
          r_d.rd_cnt = 2'h0;
          r_d.wr_cnt = 2'h0;
        end
      end
      dcc_pkg::DCC_REQ: begin
        if (bus_ack_in) begin
          r_d.state = dcc_pkg::DCC_RD;
        end
      end
      dcc_pkg::DCC_RD: begin
        if (adc_push) begin
          r_d.rd_cnt = r_q.rd_cnt + 2'h1;
        end else if (!is_adc && !r_q.bus_rd && r_q.rd_cnt != nb &&
                     data_if.in_ready) begin
          // one read in flight at a time keeps the buffer from overflow
          r_d.bus_rd = 1'b1;
          r_d.bus_addr = rd_addr;
          r_d.rd_cnt = r_q.rd_cnt + 2'h1;
        end
        if (r_q.rd_cnt == nb && !r_q.bus_rd) begin
          r_d.state = dcc_pkg::DCC_WR;
        end
      end
      dcc_pkg::DCC_WR: begin
        // one byte per cycle while the buffer holds data
        if (data_if.out_valid) begin
          r_d.bus_wr = 1'b1;
          r_d.bus_addr = wr_addr;
          r_d.bus_wdata = data_if.out_data;
          r_d.wr_cnt = r_q.wr_cnt + 2'h1;
          if (r_q.wr_cnt + 2'h1 == nb) begin
            r_d.state = dcc_pkg::DCC_FIN;
          end
        end
      end
      dcc_pkg::DCC_FIN: begin
        r_d.bus_req = 1'b0;
        r_d.state = dcc_pkg::DCC_IDLE;
        r_d.pend[r_q.sel] = 1'b0;
        if (is_adc) begin
          r_d.adc_irq = 1'b1;
        end else if (r_q.cur[ch] == chan_end_addr_in[ch]) begin
          r_d.cur[ch] = chan_start_addr_in[ch];
          r_d.irq[ch] = chan_irq_en_in[ch];
          if (chan_single_pass_in[ch]) begin
            r_d.en[ch] = 1'b0;
          end
          // otherwise the enable is left standing
        end else begin
          r_d.cur[ch] = r_q.cur[ch] + `DCC_ADDR_W'(nb);
        end
      end
      default: begin
        r_d.state = dcc_pkg::DCC_IDLE;
        r_d.bus_req = 1'b0;
      end
    endcase

    // a software set beats the end-of-block clear so the channel re-arms
    for (int i = 0; i < `DCC_NUM_CH; i++) begin
      if (chan_enable_clr_in[i]) begin
        r_d.en[i] = 1'b0;
      end
      if (chan_enable_set_in[i]) begin
        r_d.en[i] = 1'b1;
        r_d.cur[i] = chan_start_addr_in[i];
      end
      // latch the selected trigger; set wins over the service clear
      if (trig_in[chan_trig_sel_in[i]] && r_d.en[i]) begin
        r_d.pend[i] = 1'b1;
      end
      if (!r_d.en[i] && !(r_q.state != dcc_pkg::DCC_IDLE &&
                          r_q.sel == 2'(i))) begin
        r_d.pend[i] = 1'b0;
      end
    end

    // sequence the converter one single shot at a time
    if (adc_done_in && r_q.adc_busy) begin
      r_d.adc_busy = 1'b0;
      r_d.adc_res = adc_data_in;
      r_d.pend[2] = 1'b1;
    end else if (adc_enable_in && !r_q.adc_busy && !r_q.pend[2]) begin
      r_d.adc_start = 1'b1;
      r_d.adc_busy = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus_req_out = r_q.bus_req;
  assign bus_rd_out = r_q.bus_rd;
  assign bus_wr_out = r_q.bus_wr;
  assign bus_addr_out = r_q.bus_addr;
  assign bus_wdata_out = r_q.bus_wdata;
  assign chan_enable_out = r_q.en;
  assign chan_cur_addr_out = r_q.cur;
  assign chan_irq_out = r_q.irq;
  assign adc_start_out = r_q.adc_start;
  assign adc_irq_out = r_q.adc_irq;

endmodule : dcc_top

// ---- dcc_cpu_model.sv ----
`timescale 1ns/1ps
module dcc_cpu_model (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic req_in,
  input wire logic rd_in,
  input wire dcc_pkg::dcc_addr_t addr_in,
  input wire logic slow_in,
  output logic ack_out,
  output logic [7:0] rdata_out
);
  logic [1:0] wait_q;
  logic [7:0] last_q;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q <= 2'h0;
      ack_out <= 1'b0;
      last_q <= 8'h00;
    end else begin
      last_q <= rdata_out;
      if (!req_in) begin
        wait_q <= 2'h0;
        ack_out <= 1'b0;
      end else if (!slow_in || wait_q == 2'h3) ack_out <= 1'b1;
      else wait_q <= wait_q + 2'h1;
    end
  end
  // idle data toggles so a stale byte never looks valid
  assign rdata_out = rd_in ? addr_in[7:0] ^ 8'h5a : ~last_q;
endmodule : dcc_cpu_model

// ---- dcc_top_checker.sv ----
`timescale 1ns/1ps
module dcc_top_checker (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] chan_word_in,
  input wire logic [1:0] chan_irq_en_in,
  input wire logic [1:0] chan_single_pass_in,
  input wire logic [1:0] chan_enable_set_in,
  input wire logic [1:0] chan_enable_clr_in,
  input wire dcc_pkg::dcc_addr_t [1:0] chan_start_addr_in,
  input wire dcc_pkg::dcc_addr_t [1:0] chan_end_addr_in,
  input wire logic bus_ack_in,
  input wire logic bus_req_out,
  input wire logic bus_rd_out,
  input wire logic bus_wr_out,
  input wire logic [1:0] chan_enable_out,
  input wire dcc_pkg::dcc_addr_t [1:0] chan_cur_addr_out,
  input wire logic [1:0] chan_irq_out,
  input wire logic adc_start_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_access_granted:
    assert property ((bus_rd_out || bus_wr_out) |-> bus_req_out && bus_ack_in)
    else $error("bus strobe outside a granted cycle");
  a_first_access:
    assert property ($rose(bus_ack_in) |-> ##2 bus_rd_out or ##5 bus_wr_out)
    else $error("first access not at fixed distance from grant");
  a_release_after_wr:
    assert property ($fell(bus_req_out) |-> $past(bus_wr_out))
    else $error("bus released without a final write");
  a_irq_at_end:
    assert property (chan_irq_out[0] |-> chan_irq_en_in[0] &&
      $past(bus_wr_out) && chan_cur_addr_out[0] == chan_start_addr_in[0])
    else $error("channel interrupt without end of block");
  a_pass_clear:
    assert property ($fell(chan_enable_out[1]) |-> $past(chan_enable_clr_in[1])
      || chan_single_pass_in[1] && $past(bus_wr_out))
    else $error("channel disabled without cause");
  a_keep_enabled:
    assert property (chan_enable_out[0] && !chan_single_pass_in[0] &&
      !chan_enable_clr_in[0] |=> chan_enable_out[0])
    else $error("looping channel lost its enable");
  a_addr_step:
    assert property ($changed(chan_cur_addr_out[0]) &&
      !$past(chan_enable_set_in[0]) |-> chan_cur_addr_out[0] ==
      ($past(chan_cur_addr_out[0]) == chan_end_addr_in[0] ?
      chan_start_addr_in[0] : $past(chan_cur_addr_out[0]) +
      (chan_word_in[0] ? 12'h2 : 12'h1)))
    else $error("current address moved by a wrong step");
  a_adc_spacing:
    assert property (adc_start_out |=> !adc_start_out [*8])
    else $error("converter restarted too early");
  c_end_irq: cover property (chan_irq_out[0]);
  c_pass_off: cover property ($fell(chan_enable_out[1]));
  c_adc_run: cover property (adc_start_out);
endmodule : dcc_top_checker

bind dcc_top dcc_top_checker dcc_top_checker_i (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .chan_word_in(chan_word_in), .chan_irq_en_in(chan_irq_en_in),
  .chan_single_pass_in(chan_single_pass_in),
  .chan_enable_set_in(chan_enable_set_in),
  .chan_enable_clr_in(chan_enable_clr_in),
  .chan_start_addr_in(chan_start_addr_in),
  .chan_end_addr_in(chan_end_addr_in), .bus_ack_in(bus_ack_in),
  .bus_req_out(bus_req_out), .bus_rd_out(bus_rd_out),
  .bus_wr_out(bus_wr_out), .chan_enable_out(chan_enable_out),
  .chan_cur_addr_out(chan_cur_addr_out), .chan_irq_out(chan_irq_out),
  .adc_start_out(adc_start_out));

// ---- dcc_top_tb.sv ----
`timescale 1ns/1ps
module dcc_top_tb;
  logic clk, rst_n, aen, adone, ack, slow, req, rd, wr, ast, airq;
  logic [7:0] trig, rdat, wdat;
  logic [1:0] es, ec, tp, wd, ie, sp, en, irq;
  logic [1:0][2:0] tsel;
  logic [9:0] adat;
  dcc_pkg::dcc_addr_t ra, addr;
  dcc_pkg::dcc_addr_t [1:0] sa, ea, pa, cur;
  logic [19:0] wq[$];
  int fail_count, checks_done, irqs, airqs, irq1s;

  dcc_top dcc_top_i (.sys_clk_in(clk), .reset_n_in(rst_n), .trig_in(trig),
    .chan_trig_sel_in(tsel), .chan_enable_set_in(es),
    .chan_enable_clr_in(ec), .chan_to_periph_in(tp), .chan_word_in(wd),
    .chan_irq_en_in(ie), .chan_single_pass_in(sp),
    .chan_start_addr_in(sa), .chan_end_addr_in(ea),
    .chan_periph_addr_in(pa), .adc_enable_in(aen), .adc_done_in(adone),
    .adc_data_in(adat), .adc_result_addr_in(ra), .bus_ack_in(ack),
    .bus_rdata_in(rdat), .bus_req_out(req), .bus_rd_out(rd),
    .bus_wr_out(wr), .bus_addr_out(addr), .bus_wdata_out(wdat),
    .chan_enable_out(en), .chan_cur_addr_out(cur), .chan_irq_out(irq),
    .adc_start_out(ast), .adc_irq_out(airq));
  dcc_cpu_model dcc_cpu_model_i (.sys_clk_in(clk), .reset_n_in(rst_n),
    .req_in(req), .rd_in(rd), .addr_in(addr), .slow_in(slow),
    .ack_out(ack), .rdata_out(rdat));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr) wq.push_back({addr, wdat});
    if (irq[0]) irqs++;
    if (irq[1]) irq1s++;
    if (airq) airqs++;
  end

  task chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task enable(input int c);
    @(negedge clk) es[c] = 1'b1;
    @(negedge clk) es = 2'h0;
  endtask : enable

  task fire(input int k, input int n);
    int i;
    wq.delete();
    @(negedge clk) trig[k] = 1'b1;
    @(negedge clk) trig = 8'h00;
    for (i = 0; i < 40 && wq.size() < n; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : fire

  task t_byte;
    sa[0] = 12'h100;
    ea[0] = 12'h101;
    pa[0] = 12'h0f5;
    ie[0] = 1'b1;
    enable(0);
    fire(3, 1);
    chk(wq[0], {12'h100, 8'haf});
    chk({8'h00, cur[0]}, 20'h00101);
    chk({19'h0, req}, 20'h00000);
    fire(3, 1);
    chk(wq[0], {12'h101, 8'haf});
    chk({8'h00, cur[0]}, 20'h00100);
    chk(20'(irqs), 20'h00001);
    chk({19'h0, en[0]}, 20'h00001);
    fire(3, 1);
    chk(wq[0], {12'h100, 8'haf});
    fire(5, 1);
    chk(20'(wq.size()), 20'h00000);
    @(negedge clk) ec[0] = 1'b1;
    @(negedge clk) ec = 2'h0;
    chk({19'h0, en[0]}, 20'h00000);
    fire(3, 1);
    chk(20'(wq.size()), 20'h00000);
    $display("test byte done");
  endtask : t_byte

  task t_word;
    slow = 1'b1;
    tp[1] = 1'b1;
    wd[1] = 1'b1;
    sp[1] = 1'b1;
    ie[1] = 1'b1;
    sa[1] = 12'h200;
    ea[1] = 12'h200;
    pa[1] = 12'h0c0;
    enable(1);
    fire(6, 2);
    chk(wq[0], {12'h0c0, 8'h5a});
    chk(wq[1], {12'h0c1, 8'h5b});
    chk({19'h0, en[1]}, 20'h00000);
    chk({8'h00, cur[1]}, 20'h00200);
    fire(6, 1);
    chk(20'(wq.size()), 20'h00000);
    chk(20'(irq1s), 20'h00001);
    $display("test word done");
  endtask : t_word

  task t_adc;
    int i;
    ra = 12'h300;
    aen = 1'b1;
    for (i = 0; i < 20 && !ast; i++) @(negedge clk);
    chk({19'h0, ast}, 20'h00001);
    repeat (12) @(negedge clk);
    wq.delete();
    adone = 1'b1;
    adat = 10'h2a5;
    @(negedge clk) adone = 1'b0;
    for (i = 0; i < 40 && wq.size() < 2; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    aen = 1'b0;
    chk(wq[0], {12'h300, 8'h02});
    chk(wq[1], {12'h301, 8'ha5});
    chk(20'(airqs), 20'h00001);
    $display("test converter done");
  endtask : t_adc

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    {aen, adone, slow, trig, es, ec, tp, wd, ie, sp, adat} = '0;
    {sa, ea, pa, ra} = '0;
    tsel = {3'h6, 3'h3};
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_byte();
    t_word();
    t_adc();
    test_done();
  end

  initial begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule : dcc_top_tb
